// ### scs_device.sv
// Secondary core start control: the device end of the register bus.
// It stores the clock gate, the reset release and the boot vector of
// the secondary core and drives them straight to that core's inputs.
// Assumes one clock clk_sys at 40 MHz and an asynchronous active-low
// chip reset resetn; the bus master keeps the strobe discipline.
//
// Behaviour
// - After reset, secondary core stays stopped: clock off, reset released.
// - Primary core enables clock, releases reset.
// - Bit 3 gates clock: 1 stops, resets 1.
// - Bit 5 releases reset: 0 holds, resets 1.
// - Control write needs key 0xc0c4 in 31:16.
// - Reserved control bits read zero; write zeros.
// - Boot vector register, read/write, resets to zero.
// - Start only after image sits in memory.
`timescale 1ns/1ps

module scs_device (
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   scs_bus_if.device        bus,
   output logic             secondary_clock_gate,
   output logic             secondary_reset_release,
   output logic [31:0]      secondary_boot_vector
);

   // Address decode of the two device registers.
   wire        hit_control;
   wire        hit_boot;
   wire        key_ok;
   wire        write_control;
   wire        write_boot;

   assign hit_control = (bus.bus_addr == scs_pkg::OFS_CPU_CONTROL);
   assign hit_boot    = (bus.bus_addr == scs_pkg::OFS_BOOT_VECTOR);

   // The key guards every field of the control register.
   assign key_ok = (bus.bus_wdata[31:scs_pkg::KEY_LSB]
                    == scs_pkg::WRITE_KEY);

   // A control write without the key is dropped whole.
   assign write_control = bus.bus_wr && hit_control && key_ok;

   // The boot vector needs no key and takes all 32 bits.
   assign write_boot = bus.bus_wr && hit_boot;

   // Next values of the two control fields, taken from the bus.
   wire        next_clock_gate;
   wire        next_reset_release;

   assign next_clock_gate    = bus.bus_wdata[scs_pkg::BIT_CLOCK_GATE];
   assign next_reset_release = bus.bus_wdata[scs_pkg::BIT_RST_RELEASE];

   // Clock gate field: 1 keeps the secondary clock stopped.
   // Reset leaves the clock stopped, so the core cannot run even
   // though its reset release bit comes up set.
   scs_field #(
      .WIDTH (1),
      .RESET (scs_pkg::RST_CLOCK_GATE)
   ) u_clock_gate (
      .clk_sys    (clk_sys),
      .resetn     (resetn),
      .load       (write_control),
      .next_value (next_clock_gate),
      .value      (secondary_clock_gate)
   );

   // Reset release field: 0 holds the core in reset, 1 lets it go.
   scs_field #(
      .WIDTH (1),
      .RESET (scs_pkg::RST_RST_RELEASE)
   ) u_reset_release (
      .clk_sys    (clk_sys),
      .resetn     (resetn),
      .load       (write_control),
      .next_value (next_reset_release),
      .value      (secondary_reset_release)
   );

   // Boot vector: the secondary core fetches its start from here.
   scs_field #(
      .WIDTH (32),
      .RESET (scs_pkg::RST_BOOT_VECTOR)
   ) u_boot_vector (
      .clk_sys    (clk_sys),
      .resetn     (resetn),
      .load       (write_boot),
      .next_value (bus.bus_wdata),
      .value      (secondary_boot_vector)
   );

   // Read image of the control register.
   // Reserved bits and the key field read as zero, so software that
   // reads, modifies and writes back must still insert the key.
   wire [31:0] control_image;

   assign control_image = {
      16'h0000,
      10'h000,
      secondary_reset_release,
      1'h0,
      secondary_clock_gate,
      3'h0
   };

   // Read multiplexer; an unmapped address reads as zero.
   wire [31:0] read_mux;

   assign read_mux = hit_control ? control_image :
                     hit_boot    ? secondary_boot_vector :
                                   32'h0000_0000;

   // Read data stand in the cycle after the strobe and only there.
   // Outside that cycle the bus reads zero, which keeps a stale
   // answer from being mistaken for a fresh one.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         bus.bus_rdata <= 32'h0000_0000;
      end else if (bus.bus_rd) begin
         bus.bus_rdata <= read_mux;
      end else begin
         bus.bus_rdata <= 32'h0000_0000;
      end
   end

endmodule

// ### scs_field.sv
// One storage field with a load enable and a constant reset value.
// Assumes clk_sys and an asynchronous active-low reset from its parent.
`timescale 1ns/1ps

module scs_field #(
   parameter int              WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET = '0
) (
   input  wire logic             clk_sys,
   input  wire logic             resetn,
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] next_value,
   output logic      [WIDTH-1:0] value
);

   // Holds its value until loaded; reset gives the constant.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         value <= RESET;
      end else if (load) begin
         value <= next_value;
      end
   end

endmodule

// ### scs_if.sv
// Register bus between the starter (master) and the start control device.
// Assumes both ends share clk_sys; the interface carries no clock.
`timescale 1ns/1ps

interface scs_bus_if;
   logic [scs_pkg::ADDR_W-1:0] bus_addr;
   logic [scs_pkg::DATA_W-1:0] bus_wdata;
   logic                       bus_wr;
   logic                       bus_rd;
   logic [scs_pkg::DATA_W-1:0] bus_rdata;

   // The starter drives requests and reads answers.
   modport starter (
      output bus_addr,
      output bus_wdata,
      output bus_wr,
      output bus_rd,
      input  bus_rdata
   );

   // The device takes requests and returns read data.
   modport device (
      input  bus_addr,
      input  bus_wdata,
      input  bus_wr,
      input  bus_rd,
      output bus_rdata
   );
endinterface

// ### scs_pkg.sv
// Shared constants for the secondary core start control block.
// Assumes both ends and the interface refer to every name through scs_pkg::.
package scs_pkg;

   // Register bus widths and device register offsets.
   localparam int          ADDR_W          = 12;
   localparam int          DATA_W          = 32;
   localparam logic [11:0] OFS_CPU_CONTROL = 12'h800;
   localparam logic [11:0] OFS_BOOT_VECTOR = 12'h804;

   // Control register field positions and the write key.
   localparam int          BIT_CLOCK_GATE  = 3;
   localparam int          BIT_RST_RELEASE = 5;
   localparam int          KEY_LSB         = 16;
   localparam logic [15:0] WRITE_KEY       = 16'hc0c4;

   // Reset values of the device fields.
   localparam logic        RST_CLOCK_GATE  = 1'h1;
   localparam logic        RST_RST_RELEASE = 1'h1;
   localparam logic [31:0] RST_BOOT_VECTOR = 32'h0000_0000;

   // Starter software port: offsets and field positions.
   localparam int          SW_ADDR_W       = 4;
   localparam logic [3:0]  SW_OFS_SETUP    = 4'h0;
   localparam logic [3:0]  SW_OFS_COMMAND  = 4'h4;
   localparam logic [3:0]  SW_OFS_BOOT     = 4'h8;
   localparam logic [3:0]  SW_OFS_STATUS   = 4'hc;
   localparam int          SW_BIT_READY    = 0;
   localparam int          SW_BIT_START    = 0;
   localparam int          SW_BIT_HALT     = 1;
   localparam int          SW_BIT_BUSY     = 0;
   localparam int          SW_BIT_RUNNING  = 1;
   localparam int          SW_BIT_REFUSED  = 2;

   // Sequencer states of the starter.
   typedef enum logic [2:0] {
      SCS_IDLE     = 3'b000,
      SCS_WR_BOOT  = 3'b001,
      SCS_WR_CLOCK = 3'b010,
      SCS_WR_RUN   = 3'b011,
      SCS_WR_HALT  = 3'b100
   } scs_state_t;

endpackage

// ### scs_props.sv
// Checker for the bus between starter and device, and the core outputs.
// Assumes it is instantiated beside that bus and runs on clk_sys.
`timescale 1ns/1ps

module scs_props (
   input wire logic        clk_sys,
   input wire logic        resetn,
   input wire logic [11:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   input wire logic        bus_wr,
   input wire logic        bus_rd,
   input wire logic [31:0] bus_rdata,
   input wire logic        gate,
   input wire logic        rel,
   input wire logic [31:0] vec
);
   // Decode of the writes that may move the outputs.
   wire ctl_wr = bus_wr && bus_addr == scs_pkg::OFS_CPU_CONTROL;
   wire keyed  = bus_wdata[31:16] == scs_pkg::WRITE_KEY;
   wire vec_wr = bus_wr && bus_addr == scs_pkg::OFS_BOOT_VECTOR;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   key_refused_a:
      assert property (ctl_wr && !keyed |=> $stable({gate, rel}))
      else $error("Unkeyed control write moved an output.");
   gate_load_a:
      assert property (ctl_wr && keyed |=> gate == $past(bus_wdata[3]))
      else $error("Clock gate does not follow bit 3.");
   release_load_a:
      assert property (ctl_wr && keyed |=> rel == $past(bus_wdata[5]))
      else $error("Reset release does not follow bit 5.");
   vec_load_a:
      assert property (vec_wr |=> vec == $past(bus_wdata))
      else $error("Boot vector not loaded.");
   ctl_hold_a:
      assert property (!(ctl_wr && keyed) |=> $stable({gate, rel}))
      else $error("Control outputs moved without a keyed write.");
   vec_hold_a:
      assert property (!vec_wr |=> $stable(vec))
      else $error("Boot vector moved without a write.");
   reset_value_a:
      assert property ($rose(resetn) |-> gate && rel && vec == 32'h0)
      else $error("Core not held after reset.");
   rdata_idle_a:
      assert property (!bus_rd |=> bus_rdata == 32'h0)
      else $error("Read data not zero outside a read.");

   cover property (ctl_wr && keyed);
   cover property (vec_wr);
   cover property ($fell(gate));
endmodule

// ### scs_starter.sv
// Starter: the primary core side that brings the secondary core up.
// Software gives orders over a plain port; the starter issues the
// keyed register writes on the device bus.
// Assumes one clock clk_sys and asynchronous active-low reset resetn.
`timescale 1ns/1ps

module scs_starter (
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   scs_bus_if.starter       bus,
   input  wire logic [3:0]  sw_addr,
   input  wire logic [31:0] sw_wdata,
   input  wire logic        sw_wr,
   input  wire logic        sw_rd,
   output logic      [31:0] sw_rdata
);

   scs_pkg::scs_state_t state;
   scs_pkg::scs_state_t next_state;
   logic        image_ready;
   logic [31:0] boot_address;
   logic        running;
   logic        refused;

   // Software port decode.
   wire hit_setup;
   wire hit_command;
   wire hit_boot;
   wire hit_status;
   wire start_req;
   wire halt_req;
   wire idle;
   wire start_ok;
   wire start_bad;
   wire clear_refused;

   assign hit_setup   = (sw_addr == scs_pkg::SW_OFS_SETUP);
   assign hit_command = (sw_addr == scs_pkg::SW_OFS_COMMAND);
   assign hit_boot    = (sw_addr == scs_pkg::SW_OFS_BOOT);
   assign hit_status  = (sw_addr == scs_pkg::SW_OFS_STATUS);
   assign idle        = (state == scs_pkg::SCS_IDLE);
   assign start_req   = sw_wr && hit_command &&
                        sw_wdata[scs_pkg::SW_BIT_START];
   assign halt_req    = sw_wr && hit_command &&
                        sw_wdata[scs_pkg::SW_BIT_HALT];
   // A start is taken only once software marks the image loaded.
   assign start_ok    = idle && start_req && image_ready;
   assign start_bad   = start_req && !(idle && image_ready);
   assign clear_refused = sw_wr && hit_status &&
                          sw_wdata[scs_pkg::SW_BIT_REFUSED];

   // Sequencer: boot vector first, then clock on under reset, then
   // reset release, so the core never runs from a stale vector.
   always_comb begin
      next_state = state;
      case (state)
         scs_pkg::SCS_IDLE: begin
            if (start_ok) begin
               next_state = scs_pkg::SCS_WR_BOOT;
            end else if (halt_req) begin
               next_state = scs_pkg::SCS_WR_HALT;
            end
         end
         scs_pkg::SCS_WR_BOOT:  next_state = scs_pkg::SCS_WR_CLOCK;
         scs_pkg::SCS_WR_CLOCK: next_state = scs_pkg::SCS_WR_RUN;
         scs_pkg::SCS_WR_RUN:   next_state = scs_pkg::SCS_IDLE;
         scs_pkg::SCS_WR_HALT:  next_state = scs_pkg::SCS_IDLE;
         default:               next_state = scs_pkg::SCS_IDLE;
      endcase
   end

   // Keyed control words; reserved bits are always written as zero.
   wire [31:0] word_clock;
   wire [31:0] word_run;
   wire [31:0] word_halt;

   assign word_clock = {scs_pkg::WRITE_KEY, 16'h0000};
   assign word_run   = {scs_pkg::WRITE_KEY, 16'h0020};
   assign word_halt  = {scs_pkg::WRITE_KEY, 16'h0008};

   // Bus master outputs, one write per sequencer step.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         bus.bus_wr    <= 1'b0;
         bus.bus_rd    <= 1'b0;
         bus.bus_addr  <= 12'h000;
         bus.bus_wdata <= 32'h0000_0000;
      end else begin
         bus.bus_rd <= 1'b0;
         bus.bus_wr <= (next_state != scs_pkg::SCS_IDLE);
         case (next_state)
            scs_pkg::SCS_WR_BOOT: begin
               bus.bus_addr  <= scs_pkg::OFS_BOOT_VECTOR;
               bus.bus_wdata <= boot_address;
            end
            scs_pkg::SCS_WR_CLOCK: begin
               bus.bus_addr  <= scs_pkg::OFS_CPU_CONTROL;
               bus.bus_wdata <= word_clock;
            end
            scs_pkg::SCS_WR_RUN: begin
               bus.bus_addr  <= scs_pkg::OFS_CPU_CONTROL;
               bus.bus_wdata <= word_run;
            end
            scs_pkg::SCS_WR_HALT: begin
               bus.bus_addr  <= scs_pkg::OFS_CPU_CONTROL;
               bus.bus_wdata <= word_halt;
            end
            default: begin
               bus.bus_addr  <= 12'h000;
               bus.bus_wdata <= 32'h0000_0000;
            end
         endcase
      end
   end

   // State, settings and flags; a refusal beats a clear in one cycle.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state        <= scs_pkg::SCS_IDLE;
         image_ready  <= 1'b0;
         boot_address <= 32'h0000_0000;
         running      <= 1'b0;
         refused      <= 1'b0;
      end else begin
         state <= next_state;
         if (sw_wr && hit_setup) begin
            image_ready <= sw_wdata[scs_pkg::SW_BIT_READY];
         end
         if (sw_wr && hit_boot) begin
            boot_address <= sw_wdata;
         end
         if (state == scs_pkg::SCS_WR_RUN) begin
            running <= 1'b1;
         end else if (state == scs_pkg::SCS_WR_HALT) begin
            running <= 1'b0;
         end
         refused <= start_bad || (refused && !clear_refused);
      end
   end

   // Software read port, data in the cycle after the strobe only.
   wire [31:0] sw_status;
   wire [31:0] sw_mux;

   assign sw_status = {29'h0, refused, running, !idle};
   assign sw_mux = hit_setup  ? {31'h0, image_ready} :
                   hit_boot   ? boot_address :
                   hit_status ? sw_status : 32'h0000_0000;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sw_rdata <= 32'h0000_0000;
      end else begin
         sw_rdata <= sw_rd ? sw_mux : 32'h0000_0000;
      end
   end

endmodule

// ### secondary_core_start_control_tb.sv
// Bench: starter and device joined on one bus, plus a second device
// driven straight from the bench for unkeyed and unmapped accesses.
// Assumes scs_pkg, scs_if and the design files are compiled first.
`timescale 1ns/1ps

`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
   n_errors++; $display("wrong value %s expected %h seen %h", nm, ex, got); \
   end end

module secondary_core_start_control_tb;
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wd;
      logic        gate;
      logic        rel;
      logic [31:0] vec;
   } scs_row_t;

   logic        clk_sys;
   logic        resetn;
   logic [3:0]  sw_addr;
   logic [31:0] sw_wdata;
   logic        sw_wr;
   logic        sw_rd;
   logic [31:0] sw_rdata;
   logic        gate1, rel1, gate2, rel2;
   logic [31:0] vec1, vec2, r;
   int          n_errors, n_compared, i;
   scs_row_t    rows [8] = '{
      '{12'h800, 32'hc0c4_0020, 1'h0, 1'h1, 32'h0},
      '{12'h800, 32'h0000_0008, 1'h0, 1'h1, 32'h0},
      '{12'h800, 32'hc0c5_0008, 1'h0, 1'h1, 32'h0},
      '{12'h800, 32'hc0c4_0008, 1'h1, 1'h0, 32'h0},
      '{12'h804, 32'hffff_ffff, 1'h1, 1'h0, 32'hffff_ffff},
      '{12'h808, 32'h1234_5678, 1'h1, 1'h0, 32'hffff_ffff},
      '{12'h804, 32'h0000_0000, 1'h1, 1'h0, 32'h0},
      '{12'h800, 32'hc0c4_0000, 1'h0, 1'h0, 32'h0}};

   scs_bus_if b1 ();
   scs_bus_if b2 ();

   scs_starter scs_starter_inst (.clk_sys, .resetn, .bus(b1.starter),
      .sw_addr, .sw_wdata, .sw_wr, .sw_rd, .sw_rdata);
   scs_device scs_device_inst (.clk_sys, .resetn, .bus(b1.device),
      .secondary_clock_gate(gate1), .secondary_reset_release(rel1),
      .secondary_boot_vector(vec1));
   scs_device scs_device_inst2 (.clk_sys, .resetn, .bus(b2.device),
      .secondary_clock_gate(gate2), .secondary_reset_release(rel2),
      .secondary_boot_vector(vec2));
   scs_props scs_props_inst (.clk_sys, .resetn, .bus_addr(b1.bus_addr),
      .bus_wdata(b1.bus_wdata), .bus_wr(b1.bus_wr), .bus_rd(b1.bus_rd),
      .bus_rdata(b1.bus_rdata), .gate(gate1), .rel(rel1), .vec(vec1));

   // Clock at 40 MHz.
   initial begin
      clk_sys = 1'h0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   // One software port access; read data lands in r.
   task automatic sw_io(input logic [3:0] a, input logic [31:0] d,
                        input logic wr);
      @(posedge clk_sys);
      sw_addr  <= a;
      sw_wdata <= d;
      sw_wr    <= wr;
      sw_rd    <= !wr;
      @(posedge clk_sys);
      sw_wr <= 1'h0;
      sw_rd <= 1'h0;
      #1 r = sw_rdata;
   endtask

   // One access to the bench-driven device; read data lands in r.
   task automatic bus_io(input logic [11:0] a, input logic [31:0] d,
                         input logic wr);
      @(posedge clk_sys);
      b2.bus_addr  <= a;
      b2.bus_wdata <= d;
      b2.bus_wr    <= wr;
      b2.bus_rd    <= !wr;
      @(posedge clk_sys);
      b2.bus_wr <= 1'h0;
      b2.bus_rd <= 1'h0;
      #1 r = b2.bus_rdata;
   endtask

   // Polls status until idle with the running flag as asked, bounded.
   task automatic wait_run(input logic run);
      int k;
      for (k = 0; k < 20; k++) begin
         sw_io(scs_pkg::SW_OFS_STATUS, 32'h0, 1'h0);
         if (r[1] === run && r[0] === 1'h0) break;
      end
      if (k == 20) begin
         n_errors++;
         finish_test();
      end
   endtask

   task automatic finish_test();
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // Main sequence: reset, table rows, then the starter cases.
   initial begin
      {resetn, sw_addr, sw_wdata, sw_wr, sw_rd} = '0;
      {b2.bus_addr, b2.bus_wdata, b2.bus_wr, b2.bus_rd} = '0;
      n_errors = 0;
      n_compared = 0;
      repeat (6) @(posedge clk_sys);
      resetn <= 1'h1;
      @(posedge clk_sys);
      #1 `CHK("held", 4'hf, {gate1, rel1, gate2, rel2})
      `CHK("reset vector", 64'h0, {vec1, vec2})
      for (i = 0; i < 8; i++) begin
         bus_io(rows[i].addr, rows[i].wd, 1'h1);
         `CHK("outputs", {rows[i].gate, rows[i].rel}, {gate2, rel2})
         `CHK("vector", rows[i].vec, vec2)
         bus_io(scs_pkg::OFS_CPU_CONTROL, 32'h0, 1'h0);
         `CHK("control", {26'h0, rows[i].rel, 1'h0, rows[i].gate, 3'h0}, r)
         bus_io(scs_pkg::OFS_BOOT_VECTOR, 32'h0, 1'h0);
         `CHK("boot read", rows[i].vec, r)
      end
      bus_io(12'h808, 32'h0, 1'h0);
      `CHK("unmapped", 32'h0, r)
      // Start before the image is ready must be refused.
      sw_io(scs_pkg::SW_OFS_COMMAND, 32'h1, 1'h1);
      sw_io(scs_pkg::SW_OFS_STATUS, 32'h0, 1'h0);
      `CHK("refused", 32'h4, r)
      `CHK("still held", 2'h3, {gate1, rel1})
      sw_io(scs_pkg::SW_OFS_STATUS, 32'h4, 1'h1);
      sw_io(scs_pkg::SW_OFS_SETUP, 32'h1, 1'h1);
      sw_io(scs_pkg::SW_OFS_BOOT, 32'h2000_0400, 1'h1);
      sw_io(scs_pkg::SW_OFS_COMMAND, 32'h1, 1'h1);
      sw_io(scs_pkg::SW_OFS_COMMAND, 32'h1, 1'h1);
      wait_run(1'h1);
      `CHK("status", 32'h6, r)
      `CHK("started", {2'h1, 32'h2000_0400}, {gate1, rel1, vec1})
      sw_io(scs_pkg::SW_OFS_COMMAND, 32'h2, 1'h1);
      wait_run(1'h0);
      `CHK("halted", 2'h2, {gate1, rel1})
      sw_io(scs_pkg::SW_OFS_COMMAND, 32'h1, 1'h1);
      wait_run(1'h1);
      // Reset in mid-run must hold the core again.
      @(posedge clk_sys) resetn <= 1'h0;
      #1 `CHK("reset again", {2'h3, 32'h0}, {gate1, rel1, vec1})
      repeat (2) @(posedge clk_sys);
      resetn <= 1'h1;
      repeat (2) @(posedge clk_sys);
      #1 `CHK("held after release", {2'h3, 32'h0}, {gate1, rel1, vec1})
      `CHK("bus quiet", 1'h0, b1.bus_wr)
      sw_io(scs_pkg::SW_OFS_STATUS, 32'h0, 1'h0);
      `CHK("status after reset", 32'h0, r)
      finish_test();
   end
endmodule
